// >>> swe_consts.svh
// opcodes, field positions, reset values and timing defaults
`ifndef SWE_CONSTS_SVH
`define SWE_CONSTS_SVH
`define SWE_OP_MAIN      4'ha
`define SWE_OP_SEC       4'hb
`define SWE_OP_LOCK      4'h2
`define SWE_OP_ZONE      4'h7
`define SWE_OP_FRZ       4'h1
`define SWE_OP_ID        4'hc
`define SWE_OP_SLOW      4'hd
`define SWE_OP_FAST      4'he
`define SWE_OP_MSB       7
`define SWE_OP_LSB       4
`define SWE_SA_MSB       3
`define SWE_SA_LSB       1
`define SWE_RW_BIT       0
`define SWE_SEC_USER_LO  5'h10
`define SWE_SEC_RSVD_LO  5'h08
`define SWE_LOCK_KEY     4'h6
`define SWE_SLOW_RST     1'b0
`define SWE_ZONE_RST     4'h0
`define SWE_WR_CYC_DFLT  200000
`define SWE_DSCHG_DFLT   6000
`define SWE_HOLD0_DFLT   4
`endif

// >>> swe_pkg.sv
// types shared by the command and write path
package swe_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_MEM, ST_DATA, ST_ACK, ST_SKIP
   } swe_state_e;
   typedef struct packed {
      logic start;   // start condition seen
      logic stop;    // stop condition seen
      logic bit_vld; // input bit frame decoded
      logic bit_val; // its value
      logic rd_slot; // master asks for an output bit
   } swe_frame_s;
   typedef struct packed {
      logic       busy;
      logic       slow;
      logic       locked;
      logic       frozen;
      logic [3:0] zone_rom;
   } swe_status_s;
endpackage

// >>> swe_cmd_write.sv
// command decode, acknowledge and write cycle of the single-wire eeprom
// Operation
// R1 - opcode 1010 reaches the 128-byte main array, addresses 00h-7Fh
// R2 - opcode 1011 reaches the 32-byte security register
// R3 - security bytes 00h-07h serial, 08h-0Fh reserved, 10h-1Fh user
// R4 - opcode 0010 permanently locks the user security bytes
// R5 - four main-array zones, each made read-only via opcode 0111
// R6 - opcode 0001 freezes zone state; no further zone becomes read-only
// R7 - opcode 1100 is acknowledged as the identification query
// R8 - opcode 1101 sets slow mode; fast-only variant answers NACK
// R9 - opcode 1110 sets fast mode, the reset default, always ACKed
// R10 - master sends start, address byte, memory byte, data bytes, stop
// R11 - stop off a completed data byte boundary aborts the write
// R12 - commands are ignored while an internal write runs
// R13 - a short low pulse during a write gets a NACK
// R14 - line low past discharge time ends the write uncommitted
// R15 - byte write uses a 7-bit word address and one data byte
// R16 - ACK after device byte, memory byte and each data byte
// R17 - stop is a null frame with the line high
// R18 - valid stop starts a self-timed cycle of bounded length
// R19 - master keeps other bus devices quiet during a write
// R20 - an aborted write touches only the bytes being programmed
// R21 - master aborting a write holds the line low long enough
// R22 - top memory address bit is ignored on main-array writes
// R23 - address byte: opcode 7:4, slave 3:1, r/w 0; else silent
// R24 - logic 0 pulls the line low, logic 1 leaves it released
// R25 - only user security bytes are ever programmed
`timescale 1ns/10ps
`include "swe_consts.svh"
module swe_cmd_write #(
   parameter int         WR_CYC   = `SWE_WR_CYC_DFLT, // write cycle
   parameter int         DSCHG    = `SWE_DSCHG_DFLT,  // discharge abort
   parameter int         HOLD0    = `SWE_HOLD0_DFLT,  // low hold cycles
   parameter logic [2:0] SLV_ADDR = 3'h0,             // slave address
   parameter bit         DUAL     = 1'b1,             // slow mode exists
   parameter logic [63:0] SERIAL  = 64'h0123456789abcdef // arbitrary
) (
   input  wire logic               clk,       // 40 mhz clock
   input  wire logic               sys_rst,   // async reset, high
   input  wire swe_pkg::swe_frame_s frm,      // decoded bus events
   input  wire logic               sio_i,     // line level from pin
   output logic                    sio_o,     // line drive value
   output logic                    sio_oe,    // high while pulling low
   input  wire logic               rd_sec,    // read port selects sec
   input  wire logic [6:0]         rd_addr,   // read port address
   output logic [7:0]              rd_data,   // read port data
   output swe_pkg::swe_status_s    status     // mode and busy state
);
   import swe_pkg::*;

   //--------------------------------------------------------------
   // storage and state
   //--------------------------------------------------------------
   logic [7:0]  mem [128];
   logic [7:0]  sec [16];
   logic [7:0]  pbuf [8];
   logic [7:0]  pmask_r;
   swe_state_e  state_r, after_r;
   logic [7:0]  shift_r;
   logic [2:0]  bitcnt_r;
   logic [3:0]  op_r;
   logic        rw_r, ackbit_r, wr_ok_r;
   logic [6:0]  addr_r, base_r;
   logic        busy_r, slow_r, locked_r, frozen_r;
   logic [3:0]  zone_r;
   logic [19:0] wcnt_r, lowcnt_r;
   logic [7:0]  hcnt_r;
   logic        s1_r, s2_r, s3_r, low_r, oe_r, o_r;
   logic [7:0]  rd_r;

   function automatic logic op_ok(input logic [3:0] op);
      return op inside {`SWE_OP_MAIN, `SWE_OP_SEC, `SWE_OP_LOCK,
                        `SWE_OP_ZONE, `SWE_OP_FRZ, `SWE_OP_ID,
                        `SWE_OP_SLOW, `SWE_OP_FAST};
   endfunction

   //--------------------------------------------------------------
   // byte decode
   //--------------------------------------------------------------
   logic [7:0] byte_w;
   logic       done_w, nack_w, take_w, dsch_w, wdone_w, stop_ok_w;
   swe_state_e aft_w, go_w;
   assign byte_w = {shift_r[6:0], frm.bit_val};
   assign done_w = frm.bit_vld && bitcnt_r == 3'h7 && !busy_r &&
                   !frm.start && !frm.stop;

   always_comb begin
      nack_w = 1'b0;
      take_w = 1'b0;
      aft_w  = ST_SKIP;
      go_w   = ST_ACK;
      unique case (state_r)
         ST_DEV: begin
            if (!op_ok(byte_w[`SWE_OP_MSB:`SWE_OP_LSB]) ||
                byte_w[`SWE_SA_MSB:`SWE_SA_LSB] != SLV_ADDR) begin
               go_w = ST_SKIP; // [R23]
            end else if (byte_w[`SWE_RW_BIT]) begin
               aft_w = ST_SKIP;
            end else begin
               unique case (byte_w[`SWE_OP_MSB:`SWE_OP_LSB])
                  `SWE_OP_SLOW: nack_w = !DUAL; // [R8]
                  `SWE_OP_FAST, `SWE_OP_ID: nack_w = 1'b0; // [R7] [R9]
                  default: aft_w = ST_MEM; // [R1] [R2] [R16]
               endcase
            end
         end
         ST_MEM: begin
            aft_w = ST_DATA;
            if (op_r == `SWE_OP_LOCK) begin
               nack_w = locked_r ||
                        byte_w[7:4] != `SWE_LOCK_KEY; // [R4]
            end else if (op_r == `SWE_OP_FRZ) begin
               nack_w = frozen_r; // [R6]
            end
            if (nack_w) begin
               aft_w = ST_SKIP;
            end
         end
         ST_DATA: begin
            aft_w = ST_DATA;
            unique case (op_r)
               `SWE_OP_MAIN: begin
                  nack_w = zone_r[addr_r[6:5]]; // [R5]
                  take_w = !nack_w; // [R15]
               end
               `SWE_OP_SEC: begin
                  nack_w = locked_r; // [R4]
                  take_w = !locked_r &&
                           addr_r[4:0] >= `SWE_SEC_USER_LO; // [R25] [R3]
               end
               `SWE_OP_ZONE: nack_w = frozen_r; // [R6]
               `SWE_OP_LOCK: nack_w = locked_r;
               default: nack_w = frozen_r;
            endcase
            if (nack_w) begin
               aft_w = ST_SKIP;
            end
         end
         default: go_w = state_r;
      endcase
   end

   //--------------------------------------------------------------
   // command sequencing
   //--------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r  <= ST_IDLE;
         after_r  <= ST_IDLE;
         shift_r  <= 8'h00;
         bitcnt_r <= 3'h0;
         op_r     <= 4'h0;
         rw_r     <= 1'b0;
         ackbit_r <= 1'b1;
         wr_ok_r  <= 1'b0;
         addr_r   <= 7'h00;
         base_r   <= 7'h00;
      end else if (busy_r) begin
         state_r  <= ST_IDLE; // [R12]
         bitcnt_r <= 3'h0;
      end else if (frm.start) begin
         state_r  <= ST_DEV;
         bitcnt_r <= 3'h0;
         wr_ok_r  <= 1'b0;
      end else if (frm.stop) begin
         state_r  <= ST_IDLE; // [R17]
      end else if (state_r == ST_ACK) begin
         if (frm.rd_slot) begin
            state_r <= after_r;
         end
      end else if (frm.bit_vld && state_r inside {ST_DEV, ST_MEM,
                                                  ST_DATA}) begin
         shift_r  <= byte_w;
         bitcnt_r <= bitcnt_r + 3'h1;
         if (done_w) begin
            state_r  <= go_w;
            after_r  <= aft_w;
            ackbit_r <= nack_w;
            if (state_r == ST_DEV) begin
               op_r <= byte_w[`SWE_OP_MSB:`SWE_OP_LSB];
               rw_r <= byte_w[`SWE_RW_BIT];
            end
            if (state_r == ST_MEM) begin
               addr_r <= byte_w[6:0]; // [R22]
               base_r <= byte_w[6:0];
            end
            if (state_r == ST_DATA && !nack_w) begin
               wr_ok_r     <= 1'b1;
               addr_r[2:0] <= addr_r[2:0] + 3'h1; // page roll-over
            end
         end
      end
   end

   // page buffer of bytes waiting for the write cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pmask_r <= 8'h00;
      end else if (frm.start && !busy_r) begin
         pmask_r <= 8'h00;
      end else if (done_w && state_r == ST_DATA && take_w) begin
         pmask_r[addr_r[2:0]] <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (done_w && state_r == ST_DATA && take_w) begin
         pbuf[addr_r[2:0]] <= byte_w;
      end
   end

   // speed mode takes effect with the address byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slow_r <= `SWE_SLOW_RST; // [R9]
      end else if (done_w && state_r == ST_DEV && !byte_w[0] &&
                   byte_w[`SWE_SA_MSB:`SWE_SA_LSB] == SLV_ADDR) begin
         if (byte_w[7:4] == `SWE_OP_SLOW && DUAL) begin
            slow_r <= 1'b1; // [R8]
         end else if (byte_w[7:4] == `SWE_OP_FAST) begin
            slow_r <= 1'b0; // [R9]
         end
      end
   end

   //--------------------------------------------------------------
   // line input and acknowledge drive
   //--------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r  <= 1'b1;
         s2_r  <= 1'b1;
         s3_r  <= 1'b1;
         low_r <= 1'b0;
      end else begin
         s1_r <= sio_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            low_r <= !s3_r;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         oe_r   <= 1'b0;
         o_r    <= 1'b0;
         hcnt_r <= 8'h00;
      end else if (state_r == ST_ACK && frm.rd_slot && !busy_r &&
                   !ackbit_r) begin
         oe_r   <= 1'b1; // [R24] [R16]
         hcnt_r <= 8'(HOLD0 - 1);
      end else if (hcnt_r != 8'h00) begin
         hcnt_r <= hcnt_r - 8'h01;
      end else begin
         oe_r <= 1'b0; // [R13]
      end
   end

   //--------------------------------------------------------------
   // self-timed write cycle
   //--------------------------------------------------------------
   assign stop_ok_w = frm.stop && !busy_r && state_r == ST_DATA &&
                      bitcnt_r == 3'h0 && wr_ok_r; // [R11]
   assign dsch_w  = busy_r && low_r && lowcnt_r == 20'(DSCHG - 1);
   assign wdone_w = busy_r && wcnt_r == 20'(WR_CYC - 1);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_r   <= 1'b0;
         wcnt_r   <= 20'h00000;
         lowcnt_r <= 20'h00000;
      end else begin
         lowcnt_r <= (busy_r && low_r) ? lowcnt_r + 20'h1 : 20'h0;
         if (stop_ok_w) begin
            busy_r <= 1'b1; // [R18]
            wcnt_r <= 20'h00000;
         end else if (dsch_w || wdone_w) begin
            busy_r <= 1'b0; // [R14]
         end else if (busy_r) begin
            wcnt_r <= wcnt_r + 20'h1;
         end
      end
   end

   // commit only at the natural end; an abort leaves all bytes alone
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         locked_r <= 1'b0;
         frozen_r <= 1'b0;
         zone_r   <= `SWE_ZONE_RST;
      end else if (wdone_w && !dsch_w) begin
         if (op_r == `SWE_OP_LOCK) begin
            locked_r <= 1'b1; // [R4]
         end
         if (op_r == `SWE_OP_FRZ) begin
            frozen_r <= 1'b1; // [R6]
         end
         if (op_r == `SWE_OP_ZONE && !frozen_r) begin
            zone_r[base_r[1:0]] <= 1'b1; // [R5]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wdone_w && !dsch_w) begin
         for (int i = 0; i < 8; i++) begin
            if (pmask_r[i] && op_r == `SWE_OP_MAIN) begin
               mem[{addr_r[6:3], 3'(i)}] <= pbuf[i]; // [R1] [R20]
            end
            if (pmask_r[i] && op_r == `SWE_OP_SEC) begin
               sec[{addr_r[3], 3'(i)}] <= pbuf[i]; // [R2] [R25]
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_r <= 8'h00;
      end else if (!rd_sec) begin
         rd_r <= mem[rd_addr];
      end else if (rd_addr[4:0] >= `SWE_SEC_USER_LO) begin
         rd_r <= sec[rd_addr[3:0]];
      end else if (rd_addr[4:0] >= `SWE_SEC_RSVD_LO) begin
         rd_r <= 8'hff; // [R3]
      end else begin
         rd_r <= SERIAL[{rd_addr[2:0], 3'h0} +: 8];
      end
   end

   assign sio_o   = o_r;
   assign sio_oe  = oe_r;
   assign rd_data = rd_r;
   assign status  = '{busy: busy_r, slow: slow_r, locked: locked_r,
                      frozen: frozen_r, zone_rom: zone_r};

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_busy_ignore: assert property (busy_r |=> state_r == ST_IDLE) // [R12]
      else $error("command taken during write cycle");
   chk_busy_nack: assert property (busy_r && !oe_r |=> !oe_r) // [R13]
      else $error("line driven while busy");
   chk_stop_start: assert property (stop_ok_w |=> busy_r && // [R18]
      wcnt_r == 20'h0) else $error("valid stop did not start write");
   chk_stop_abort: assert property (frm.stop && !busy_r && // [R11]
      bitcnt_r != 3'h0 |=> !busy_r) else $error("mid-byte stop wrote");
   chk_cycle_bound: assert property (busy_r |-> // [R18]
      wcnt_r < 20'(WR_CYC)) else $error("write cycle overran");
   chk_dschg_end: assert property (dsch_w |=> !busy_r && // [R14]
      $stable(zone_r) && $stable(locked_r)) else $error("no abort");
   chk_ack_drive: assert property (state_r == ST_ACK && // [R16]
      frm.rd_slot && !busy_r && !ackbit_r |=> oe_r && !o_r)
      else $error("ack not driven low");
   chk_nack_float: assert property (state_r == ST_ACK && // [R24]
      frm.rd_slot && ackbit_r && !oe_r |=> !oe_r)
      else $error("nack drove the line");
   chk_lock_keep: assert property (locked_r |=> locked_r) // [R4]
      else $error("lock released");
   chk_zone_freeze: assert property (frozen_r |=> // [R6]
      $stable(zone_r)) else $error("zone changed after freeze");
   chk_fast_only: assert property (!DUAL |-> !slow_r) // [R8]
      else $error("slow mode on fast-only part");

   cov_write: cover property (stop_ok_w);
   cov_dschg: cover property (dsch_w);
   cov_lock: cover property ($rose(locked_r));
endmodule // swe_cmd_write

// >>> swe_host_model.sv
// single-wire bus master model driving decoded frames and the line
`timescale 1ns/10ps
module swe_host_model (
   input  wire logic          clk,    // bench clock
   input  wire logic          sio_oe, // device pulls line low
   output swe_pkg::swe_frame_s frm,   // decoded bus events
   output logic               sio_i   // wired line level
);
   import swe_pkg::*;
   logic host_low; // master holds line low
   // ------------------------------------------------------------
   // line: pull-up unless someone pulls low
   // ------------------------------------------------------------
   assign sio_i = ~(host_low | sio_oe);
   initial begin
      frm = '0;
      host_low = 1'b0;
   end
   // one-cycle event pulse
   task automatic pulse(input logic [4:0] f);
      @(posedge clk);
      frm <= f;
      @(posedge clk);
      frm <= '0;
   endtask
   // byte msb first, then ack slot; n = cycles the device held low
   task automatic put(input logic [7:0] b, output int n);
      for (int i = 7; i >= 0; i--) pulse({3'b001, b[i], 1'b0});
      pulse(5'b00001);
      n = 0;
      // first look lands in the cycle the device starts pulling low
      repeat (8) begin
         #1;
         if (sio_oe === 1'b1) n++;
         @(posedge clk);
      end
   endtask
   // hold the line low, long for an abort
   task automatic hold_low(input int c);
      @(posedge clk);
      host_low <= 1'b1;
      repeat (c) @(posedge clk);
      host_low <= 1'b0;
   endtask
endmodule // swe_host_model

// >>> swe_cmd_write_tb_top.sv
// self-checking testbench of the command and write path
`timescale 1ns/10ps
module swe_cmd_write_tb_top;
   import swe_pkg::*;
   localparam int WR_CYC = 50;
   localparam int DSCHG  = 10;
   localparam int HOLD0  = 4;
   logic        clk;
   logic        sys_rst;
   logic        sio_i;
   logic        sio_o;
   logic        sio_oe;
   logic        rd_sec;
   logic [6:0]  rd_addr;
   logic [7:0]  rd_data;
   swe_frame_s  frm;
   swe_status_s status;
   int          err_count;
   int          comparisons;
   swe_cmd_write #(.WR_CYC(WR_CYC), .DSCHG(DSCHG)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .frm(frm), .sio_i(sio_i),
      .sio_o(sio_o), .sio_oe(sio_oe), .rd_sec(rd_sec),
      .rd_addr(rd_addr), .rd_data(rd_data), .status(status));
   swe_host_model i_host (
      .clk(clk), .sio_oe(sio_oe), .frm(frm), .sio_i(sio_i));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic ck(input logic [7:0] got, exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // start, bytes with ack capture, optional stop
   task automatic seq(input logic [7:0] b [$], input bit stp,
                      output logic [7:0] acks);
      int n;
      acks = '0;
      i_host.pulse(5'b10000);
      foreach (b[i]) begin
         i_host.put(b[i], n);
         acks[i] = (n == HOLD0);
      end
      if (stp) i_host.pulse(5'b01000);
   endtask
   task automatic wait_idle(output int n);
      n = 0;
      repeat (WR_CYC + 20) begin
         #1;
         if (status.busy === 1'b1) n++;
         @(posedge clk);
      end
   endtask
   task automatic rd(input logic s, input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      rd_sec <= s;
      rd_addr <= a;
      repeat (2) @(posedge clk);
      #1;
      d = rd_data;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_page_write;
      logic [7:0] a;
      int n;
      seq('{8'ha0, 8'h85, 8'h5a, 8'ha5, 8'h22}, 1, a);
      ck(a, 8'h1f, "page write acks");
      #1;
      ck(status.busy, 1, "busy after stop");
      i_host.hold_low(2);
      i_host.pulse(5'b10000);
      i_host.put(8'ha0, n);
      ck(n, 0, "command while busy");
      wait_idle(n);
      rd(0, 7'h05, a);
      ck(a, 8'h5a, "byte 05");
      rd(0, 7'h06, a);
      ck(a, 8'ha5, "byte 06");
      rd(0, 7'h07, a);
      ck(a, 8'h22, "byte 07");
   endtask
   task automatic t_abort_stop;
      logic [7:0] a;
      seq('{8'ha0, 8'h07, 8'h33}, 0, a);
      ck(a, 8'h07, "acks before partial byte");
      repeat (4) i_host.pulse(5'b00110);
      i_host.pulse(5'b01000);
      repeat (3) @(posedge clk);
      #1;
      ck(status.busy, 0, "partial byte stop");
      rd(0, 7'h07, a);
      ck(a, 8'h22, "aborted byte");
   endtask
   task automatic t_discharge;
      logic [7:0] a;
      seq('{8'ha0, 8'h07, 8'h11}, 1, a);
      i_host.hold_low(DSCHG + 6);
      repeat (2) @(posedge clk);
      #1;
      ck(status.busy, 0, "discharge abort");
      rd(0, 7'h07, a);
      ck(a, 8'h22, "not programmed");
      rd(0, 7'h05, a);
      ck(a, 8'h5a, "neighbour intact");
   endtask
   task automatic t_opcodes;
      logic [8:0] t [12] = '{9'h1a0, 9'h1b0, 9'h120, 9'h170, 9'h110,
         9'h1c0, 9'h1d0, 9'h1e0, 9'h030, 9'h0f0, 9'h0a2, 9'h1a1};
      logic [7:0] a;
      foreach (t[i]) begin
         seq('{t[i][7:0]}, 1, a);
         ck(a, {7'h0, t[i][8]}, "device byte ack");
         if (t[i][7:4] == 4'hd) ck(status.slow, 1, "slow mode");
         if (t[i][7:4] == 4'he) ck(status.slow, 0, "fast mode");
      end
   endtask
   task automatic t_security;
      logic [7:0] a;
      logic [7:0] s;
      int n;
      seq('{8'hb0, 8'h12, 8'hc3, 8'h3c}, 1, a);
      ck(a, 8'h0f, "security acks");
      wait_idle(n);
      ck(n, WR_CYC, "write cycle length");
      rd(1, 7'h12, a);
      ck(a, 8'hc3, "user byte 12");
      rd(1, 7'h13, a);
      ck(a, 8'h3c, "user byte 13");
      rd(1, 7'h07, s);
      seq('{8'hb0, 8'h07, ~s}, 1, a);
      wait_idle(n);
      rd(1, 7'h07, a);
      ck(a, s, "serial kept");
      rd(1, 7'h08, a);
      ck(a, 8'hff, "reserved byte");
   endtask
   task automatic t_lock_zone;
      logic [7:0] a;
      int n;
      seq('{8'h20, 8'h60, 8'h00}, 1, a);
      wait_idle(n);
      ck(status.locked, 1, "locked");
      seq('{8'hb0, 8'h14, 8'h55}, 1, a);
      ck(a, 8'h03, "locked data nack");
      seq('{8'h70, 8'h01, 8'h00}, 1, a);
      wait_idle(n);
      ck(status.zone_rom, 4'h2, "zone 1 rom");
      seq('{8'ha0, 8'h25, 8'h77}, 1, a);
      ck(a, 8'h03, "rom zone data nack");
      seq('{8'h10, 8'h00, 8'h00}, 1, a);
      wait_idle(n);
      ck(status.frozen, 1, "frozen");
      seq('{8'h70, 8'h02, 8'h00}, 1, a);
      wait_idle(n);
      ck(status.zone_rom, 4'h2, "zone state frozen");
   endtask
   // ------------------------------------------------------------
   // clock, reset, sequence, watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      sys_rst = 1'b1;
      rd_sec = 1'b0;
      rd_addr = '0;
      err_count = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_page_write();
      t_abort_stop();
      t_discharge();
      t_opcodes();
      t_security();
      t_lock_zone();
      print_verdict();
   end
   initial begin
      #(25 * 30000);
      err_count++;
      print_verdict();
   end
endmodule // swe_cmd_write_tb_top
